// *** hw/ots_osc_trim.sv ***
// Trim registers, spread-spectrum sweep and standby control of the fast oscillator.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps

module ots_osc_trim (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_stop,
    input wire logic cpu_sleep,
    output logic [7:0] oscillator_control_code,
    output logic [1:0] coarse_range_field,
    output logic osc_standby
);

    // *****************************************************************
    // State
    // *****************************************************************
    typedef struct packed {
        logic [7:0] coarse_trim_reg;
        logic [7:0] fine_trim_value;
        logic trim_block_protection_off;
        logic [3:0] timer;
        logic phase;
        logic dir_up;
        logic signed [6:0] offset;
        logic [7:0] code;
        logic [1:0] range;
        logic standby;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } ots_state_t;

    ots_state_t s;
    ots_state_t next_s;

    logic [3:0] sweep_rate_field;
    logic [1:0] sweep_amplitude_field;
    logic ss_on;
    logic tick;
    logic signed [7:0] amp;
    logic signed [9:0] sum;
    logic setup;
    logic access;
    logic hit;
    logic guarded;

    assign sweep_rate_field = s.coarse_trim_reg[ots_pkg::RATE_LSB +: 4];
    assign sweep_amplitude_field = s.coarse_trim_reg[ots_pkg::AMP_LSB +: 2];
    assign ss_on = (sweep_rate_field != 4'h0);
    // The amplitude doubles with each code step, from 4 up to 32.
    assign amp = signed'({1'b0, ots_pkg::AMP_BASE << sweep_amplitude_field});
    // The timer is compared with greater-or-equal so that a lowered rate never strands it.
    assign tick = ss_on && !s.standby && (s.timer >= sweep_rate_field - 4'h1);
    assign sum = signed'({2'b00, s.fine_trim_value}) + 10'(s.offset);
    assign setup = psel && !penable;
    assign access = psel && penable && s.ready;
    assign hit = (paddr == ots_pkg::ADDR_COARSE) || (paddr == ots_pkg::ADDR_FINE) ||
                 (paddr == ots_pkg::ADDR_STATUS) || (paddr == ots_pkg::ADDR_UNLOCK);
    assign guarded = (paddr == ots_pkg::ADDR_COARSE) || (paddr == ots_pkg::ADDR_FINE);

    // *****************************************************************
    // Next state
    // *****************************************************************
    always_comb begin
        next_s = s;

        // The oscillator halts with the processor and restarts on wake.
        next_s.standby = cpu_stop || cpu_sleep;

        if (!ss_on) begin
            next_s.timer = 4'h0;
            next_s.phase = 1'b0;
            next_s.dir_up = 1'b1;
            next_s.offset = 7'sd0;
        end else if (tick) begin
            next_s.timer = 4'h0;
            // Each slot is two update intervals, so one sweep is 4*rate*(2*amp+1) cycles.
            next_s.phase = !s.phase;
            if (s.phase) begin
                // Turning at a peak uses one slot, so each peak is held for two slots.
                if (s.dir_up) begin
                    if (s.offset >= amp) begin
                        next_s.dir_up = 1'b0;
                    end else begin
                        next_s.offset = s.offset + 7'sd1;
                    end
                end else begin
                    if (s.offset <= -amp) begin
                        next_s.dir_up = 1'b1;
                    end else begin
                        next_s.offset = s.offset - 7'sd1;
                    end
                end
            end
        end else if (!s.standby) begin
            next_s.timer = s.timer + 4'h1;
        end

        // A lowered amplitude pulls the offset in at once rather than after a long walk back.
        if (next_s.offset > amp) begin
            next_s.offset = 7'(amp);
        end else if (next_s.offset < -amp) begin
            next_s.offset = 7'(-amp);
        end

        if (!ss_on) begin
            next_s.code = s.fine_trim_value;
        end else if (sum < 10'sd0) begin
            next_s.code = ots_pkg::CODE_MIN;
        end else if (sum > 10'sd255) begin
            next_s.code = ots_pkg::CODE_MAX;
        end else begin
            next_s.code = sum[7:0];
        end
        next_s.range = s.coarse_trim_reg[ots_pkg::RANGE_LSB +: 2];

        // The slave answers in the cycle after setup; an error is decided at setup too.
        next_s.ready = setup;
        if (setup) begin
            next_s.slverr = !hit || (pwrite && guarded && !s.trim_block_protection_off);
            if (pwrite || !hit) begin
                next_s.rdata = 32'h0000_0000;
            end else if (paddr == ots_pkg::ADDR_COARSE) begin
                next_s.rdata = {24'h00_0000, s.coarse_trim_reg};
            end else if (paddr == ots_pkg::ADDR_FINE) begin
                next_s.rdata = {24'h00_0000, s.fine_trim_value};
            end else if (paddr == ots_pkg::ADDR_STATUS) begin
                next_s.rdata = {15'h0000, s.dir_up, 8'(s.offset), s.code};
            end else begin
                next_s.rdata = {31'h0000_0000, s.trim_block_protection_off};
            end
        end else if (access) begin
            next_s.slverr = 1'b0;
            next_s.rdata = 32'h0000_0000;
        end

        // Writes land only at the completing edge and only when the setup found no fault.
        if (access && pwrite && !s.slverr) begin
            if (paddr == ots_pkg::ADDR_COARSE) begin
                next_s.coarse_trim_reg = pwdata[7:0];
            end else if (paddr == ots_pkg::ADDR_FINE) begin
                next_s.fine_trim_value = pwdata[7:0];
            end else if (paddr == ots_pkg::ADDR_UNLOCK) begin
                next_s.trim_block_protection_off = pwdata[ots_pkg::UNLOCK_BIT];
            end
        end
    end

    // *****************************************************************
    // Registers
    // *****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.coarse_trim_reg <= ots_pkg::COARSE_RESET;
            s.fine_trim_value <= ots_pkg::FINE_RESET;
            s.trim_block_protection_off <= 1'b0;
            s.timer <= 4'h0;
            s.phase <= 1'b0;
            s.dir_up <= 1'b1;
            s.offset <= 7'sd0;
            s.code <= ots_pkg::FINE_RESET;
            s.range <= ots_pkg::COARSE_RESET[1:0];
            s.standby <= 1'b0;
            s.rdata <= 32'h0000_0000;
            s.ready <= 1'b0;
            s.slverr <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;
    assign oscillator_control_code = s.code;
    assign coarse_range_field = s.range;
    assign osc_standby = s.standby;

    // *****************************************************************
    // Assertions
    // *****************************************************************
    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        !ss_on |=> (oscillator_control_code == $past(s.fine_trim_value));
    endproperty
    a_bypass: assert property (p_bypass) else $error("code differs from fine trim with sweep off");

    property p_amp_bound;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((8'(s.offset) <= $past(amp)) && (8'(s.offset) >= -$past(amp)));
    endproperty
    a_amp_bound: assert property (p_amp_bound) else $error("sweep offset beyond amplitude");

    property p_step_hold;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && !tick && $stable(s.coarse_trim_reg)) |=> $stable(s.offset);
    endproperty
    a_step_hold: assert property (p_step_hold) else $error("offset moved between updates");

    property p_half_slot;
        @(posedge pclk) disable iff (!presetn)
        (tick && !s.phase && $stable(s.coarse_trim_reg)) |=> ($stable(s.offset) && s.phase);
    endproperty
    a_half_slot: assert property (p_half_slot) else $error("offset moved on first half of a slot");

    property p_sum;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && sum >= 10'sd0 && sum <= 10'sd255) |=> (oscillator_control_code == $past(sum[7:0]));
    endproperty
    a_sum: assert property (p_sum) else $error("swept code is not trim plus offset");

    property p_clip_lo;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && sum < 10'sd0) |=> (oscillator_control_code == 8'h00);
    endproperty
    a_clip_lo: assert property (p_clip_lo) else $error("swept code wrapped below zero");

    property p_clip_hi;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && sum > 10'sd255) |=> (oscillator_control_code == 8'hff);
    endproperty
    a_clip_hi: assert property (p_clip_hi) else $error("swept code wrapped above 255");

    property p_range;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> (coarse_range_field == $past(s.coarse_trim_reg[1:0]));
    endproperty
    a_range: assert property (p_range) else $error("coarse range output lags the register");

    property p_protect;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && guarded && !s.trim_block_protection_off) |=>
            ($stable(s.coarse_trim_reg) && $stable(s.fine_trim_value));
    endproperty
    a_protect: assert property (p_protect) else $error("protected trim register was written");

    property p_standby;
        @(posedge pclk) disable iff (!presetn)
        (cpu_stop || cpu_sleep) |=> osc_standby;
    endproperty
    a_standby: assert property (p_standby) else $error("oscillator not held in standby");

    // A stopped oscillator has no cycles, so the sweep must resume exactly where it paused.
    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        (osc_standby && ss_on && $stable(s.coarse_trim_reg)) |=>
            ($stable(s.timer) && $stable(s.offset));
    endproperty
    a_frozen: assert property (p_frozen) else $error("sweep moved during standby");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        !(cpu_stop || cpu_sleep) |=> !osc_standby;
    endproperty
    a_wake: assert property (p_wake) else $error("oscillator stayed in standby after wake");

    property p_triangle;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && $stable(s.coarse_trim_reg)) |=>
            ((s.offset == $past(s.offset)) || (s.offset == $past(s.offset) + 7'sd1) ||
             (s.offset == $past(s.offset) - 7'sd1));
    endproperty
    a_triangle: assert property (p_triangle) else $error("offset jumped by more than one");

    property p_off_rest;
        @(posedge pclk) disable iff (!presetn)
        !ss_on |=> ((s.offset == 7'sd0) && s.dir_up);
    endproperty
    a_off_rest: assert property (p_off_rest) else $error("sweep state not at rest with sweep off");

    property p_turn_top;
        @(posedge pclk) disable iff (!presetn)
        (tick && s.phase && s.dir_up && (s.offset >= amp) && $stable(s.coarse_trim_reg)) |=>
            (!s.dir_up && $stable(s.offset));
    endproperty
    a_turn_top: assert property (p_turn_top) else $error("sweep did not turn at the top");

    property p_turn_bottom;
        @(posedge pclk) disable iff (!presetn)
        (tick && s.phase && !s.dir_up && (s.offset <= -amp) && $stable(s.coarse_trim_reg)) |=>
            (s.dir_up && $stable(s.offset));
    endproperty
    a_turn_bottom: assert property (p_turn_bottom) else $error("sweep did not turn at the bottom");

    property p_timer_count;
        @(posedge pclk) disable iff (!presetn)
        (ss_on && !tick && !s.standby) |=> (s.timer == $past(s.timer) + 4'h1);
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("update timer did not count");

    property p_guard_err;
        @(posedge pclk) disable iff (!presetn)
        (setup && pwrite && guarded && !s.trim_block_protection_off) |=> pslverr;
    endproperty
    a_guard_err: assert property (p_guard_err) else $error("protected write not refused");

    property p_coarse_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && (paddr == ots_pkg::ADDR_COARSE) && !s.slverr) |=>
            (s.coarse_trim_reg == $past(pwdata[7:0]));
    endproperty
    a_coarse_write: assert property (p_coarse_write) else $error("coarse write did not land");

    property p_fine_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && (paddr == ots_pkg::ADDR_FINE) && !s.slverr) |=>
            (s.fine_trim_value == $past(pwdata[7:0]));
    endproperty
    a_fine_write: assert property (p_fine_write) else $error("fine trim write did not land");

endmodule

// *** hw/ots_pkg.sv ***
// Constants shared by the fast oscillator trim and spread-spectrum block.
//
// Notes on behaviour
// - A sweep rate of zero turns spreading off and sends the fine trim value to the oscillator unchanged.
// - The amplitude code selects the largest offset, 11 for 32, 10 for 16, 01 for 8 and 00 for 4.
// - The sweep rate gives the number of oscillator cycles between two update ticks; the offset moves on every second tick.
// - A full sweep lasts four times the rate times twice the amplitude plus one cycles.
// - While spreading, the oscillator code is the fine trim plus the current offset, within the amplitude.
// - The swept code saturates at 0 and 255 and never wraps.
// - The fine trim value resets to 0x80, and a larger value means a lower frequency.
// - The coarse range field picks the range, 11 highest, then 10, 01, and 00 lowest.
// - The coarse trim register resets to 0x01 and takes writes only while trim protection is lifted.
// - The oscillator goes to standby while the processor is in stop or sleep and runs again on wake.
package ots_pkg;

    // *****************************************************************
    // Register indices and byte addresses
    // *****************************************************************
    localparam logic [15:0] IDX_COARSE = 16'ha001;
    localparam logic [15:0] IDX_FINE = 16'ha002;
    localparam logic [15:0] IDX_STATUS = 16'ha003;
    localparam logic [15:0] IDX_UNLOCK = 16'ha004;
    localparam logic [31:0] ADDR_COARSE = {14'h0000, IDX_COARSE, 2'b00};
    localparam logic [31:0] ADDR_FINE = {14'h0000, IDX_FINE, 2'b00};
    localparam logic [31:0] ADDR_STATUS = {14'h0000, IDX_STATUS, 2'b00};
    localparam logic [31:0] ADDR_UNLOCK = {14'h0000, IDX_UNLOCK, 2'b00};

    // *****************************************************************
    // Field positions
    // *****************************************************************
    localparam int RATE_LSB = 4;
    localparam int AMP_LSB = 2;
    localparam int RANGE_LSB = 0;
    localparam int UNLOCK_BIT = 0;

    // *****************************************************************
    // Reset values and sweep constants
    // *****************************************************************
    localparam logic [7:0] COARSE_RESET = 8'h01;
    localparam logic [7:0] FINE_RESET = 8'h80;
    localparam logic [6:0] AMP_BASE = 7'h04;
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam logic [7:0] CODE_MIN = 8'h00;

endpackage

// *** verification/osc_trim_spread_spectrum_tb.sv ***
// Self-checking bench for the oscillator trim and spread-spectrum block.
`timescale 1ns/100ps

module osc_trim_spread_spectrum_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic cpu_stop = 1'b0;
    logic cpu_sleep = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] code;
    logic [1:0] range;
    logic standby;
    logic running;
    logic [9:0] rank;
    logic [33:0] notes[$];
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int unsigned rnd;

    always #4 pclk = ~pclk;

    ots_osc_trim u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_stop(cpu_stop), .cpu_sleep(cpu_sleep),
        .oscillator_control_code(code), .coarse_range_field(range), .osc_standby(standby));

    ots_osc_model u_osc (.pclk(pclk), .control_code(code), .range_code(range),
        .standby(standby), .running(running), .freq_rank(rank));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    // ****************************************
    // Bus master
    // ****************************************
    // Each transfer leaves a note for the monitor before it starts.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        notes.push_back({w, err, exp});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait; the slave decides when it answers.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        logic [33:0] nt;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            nt = notes.pop_front();
            chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
            if (!nt[33]) begin
                chk("prdata", nt[31:0], prdata);
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            finish_test();
        end
    end

    // ****************************************
    // Sweep check
    // ****************************************
    // Two periods are captured so that shape, bounds and repetition are all judged.
    task automatic sweep(input int a, input int r, input int f);
        int amp, p, mx, mn, bad;
        int c[$];
        amp = 4 << a;
        p = 4 * r * (2 * amp + 1);
        mx = 0;
        mn = 255;
        bad = 0;
        apb(1'b1, ots_pkg::ADDR_FINE, 32'(f), 1'b0, 32'h0000_0000);
        apb(1'b1, ots_pkg::ADDR_COARSE, {24'h0000_00, 4'(r), 2'(a), 2'b01}, 1'b0, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        repeat (2 * p + 1) begin
            @(posedge pclk);
            c.push_back(int'(code));
        end
        for (int i = 0; i < p; i++) begin
            if (c[i] != c[i + p]) bad++;
            if (c[i + 1] - c[i] > 1 || c[i] - c[i + 1] > 1) bad++;
            mx = c[i] > mx ? c[i] : mx;
            mn = c[i] < mn ? c[i] : mn;
        end
        chk("sweep max", f + amp > 255 ? 255 : f + amp, mx);
        chk("sweep min", f - amp < 0 ? 0 : f - amp, mn);
        chk("sweep shape", 0, bad);
        apb(1'b1, ots_pkg::ADDR_COARSE, {24'h0000_00, 4'h0, 2'(a), 2'b01}, 1'b0, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk("fixed code", f, {24'h0000_00, code});
        done("sweep");
    endtask

    initial begin
        rnd = $urandom(32'h293f);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset code", 32'h0000_0080, {24'h0000_00, code});
        chk("reset range", 32'h0000_0001, {30'h0, range});
        apb(1'b0, ots_pkg::ADDR_COARSE, 32'h0, 1'b0, 32'h0000_0001);
        apb(1'b0, ots_pkg::ADDR_FINE, 32'h0, 1'b0, 32'h0000_0080);
        apb(1'b0, ots_pkg::ADDR_STATUS, 32'h0, 1'b0, 32'h0001_0080);
        apb(1'b1, ots_pkg::ADDR_STATUS, 32'h0000_00ff, 1'b0, 32'h0);
        apb(1'b1, ots_pkg::ADDR_COARSE, 32'h0000_00f3, 1'b1, 32'h0);
        apb(1'b1, ots_pkg::ADDR_FINE, 32'h0000_0011, 1'b1, 32'h0);
        apb(1'b0, 32'h0000_0100, 32'h0, 1'b1, 32'h0);
        apb(1'b0, ots_pkg::ADDR_COARSE, 32'h0, 1'b0, 32'h0000_0001);
        apb(1'b0, ots_pkg::ADDR_FINE, 32'h0, 1'b0, 32'h0000_0080);
        apb(1'b1, ots_pkg::ADDR_UNLOCK, 32'h0000_0001, 1'b0, 32'h0);
        apb(1'b0, ots_pkg::ADDR_UNLOCK, 32'h0, 1'b0, 32'h0000_0001);
        done("registers");
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, ots_pkg::ADDR_COARSE, 32'(r), 1'b0, 32'h0);
            apb(1'b0, ots_pkg::ADDR_COARSE, 32'h0, 1'b0, 32'(r));
            chk("range", 32'(r), {30'h0, range});
            chk("rank range", 32'(r), {30'h0, rank[9:8]});
        end
        done("range");
        rnd = $urandom_range(248, 8);
        apb(1'b1, ots_pkg::ADDR_FINE, rnd, 1'b0, 32'h0);
        repeat (2) @(posedge pclk);
        chk("fixed code", rnd, {24'h0000_00, code});
        // A larger trim must read as a slower oscillator in the highest range.
        chk("rank", {22'h00_0000, 2'b11, ~8'(rnd)}, {22'h00_0000, rank});
        for (int a = 0; a < 4; a++) begin
            // Software keeps the fine trim between the amplitude and 256 minus it here, so the top can clip by one.
            sweep(a, int'($urandom_range(3, 1)), int'($urandom_range(256 - (4 << a), 4 << a)));
        end
        sweep(3, 1, 240);
        sweep(3, 2, 5);
        // A rate above one keeps the update timer moving, so a frozen timer is visible.
        apb(1'b1, ots_pkg::ADDR_COARSE, 32'h0000_0030, 1'b0, 32'h0);
        for (int s = 0; s < 2; s++) begin
            cpu_stop <= (s == 0);
            cpu_sleep <= (s == 1);
            repeat (3) @(posedge pclk);
            rnd = code;
            chk("standby", 32'h1, {31'h0, standby});
            chk("running", 32'h0, {31'h0, running});
            repeat (20) @(posedge pclk);
            chk("frozen", rnd, {24'h0000_00, code});
            cpu_stop <= 1'b0;
            cpu_sleep <= 1'b0;
            repeat (3) @(posedge pclk);
            chk("awake", 32'h0, {31'h0, standby});
        end
        done("standby");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset code", 32'h0000_0080, {24'h0000_00, code});
        apb(1'b0, ots_pkg::ADDR_COARSE, 32'h0, 1'b0, 32'h0000_0001);
        apb(1'b1, ots_pkg::ADDR_FINE, 32'h0000_0011, 1'b1, 32'h0);
        done("second reset");
        chk("notes left", 32'h0, 32'(notes.size()));
        finish_test();
    end
endmodule

// *** verification/ots_osc_model.sv ***
// Behavioural model of the analog oscillator's frequency control input.
`timescale 1ns/100ps

module ots_osc_model (
    input wire logic pclk,
    input wire logic [7:0] control_code,
    input wire logic [1:0] range_code,
    input wire logic standby,
    output logic running,
    output logic [9:0] freq_rank
);
    // ****************************************
    // Frequency rank
    // ****************************************
    // A larger rank means a faster oscillator.
    // The rank is held in standby because a stopped oscillator takes no new code.
    always_ff @(posedge pclk) begin
        running <= !standby;
        if (!standby) begin
            freq_rank <= {range_code, ~control_code};
        end
    end
endmodule
